// ### verilog/pms_pkg.sv
// shared constants and types for the mii/rmii and management block
package pms_pkg;

	// ------------------------------------------------------------
	// link clock and bit timing
	// ------------------------------------------------------------
	localparam int REF_CLK_KHZ = 50000;
	localparam int BIT10_NS = 100;
	localparam int BIT10_CYC = (BIT10_NS * REF_CLK_KHZ) / 1000000;
	localparam int HB_DLY_NS = 1000;
	localparam int HB_DLY_CYC = (HB_DLY_NS * REF_CLK_KHZ) / 1000000;
	localparam int SQE_BITS = 10;
	localparam int SQE_CYC = SQE_BITS * BIT10_CYC;
	localparam logic [2:0] COL_HOLD_BITS = 3'h7;

	// ------------------------------------------------------------
	// transfer cadence in link clocks
	// ------------------------------------------------------------
	localparam logic [4:0] MII100_DIV = 5'h02;
	localparam logic [4:0] MII10_DIV = 5'h14;
	localparam logic [4:0] RMII100_DIV = 5'h01;
	localparam logic [4:0] RMII10_DIV = 5'h0a;

	// ------------------------------------------------------------
	// management frame
	// ------------------------------------------------------------
	localparam logic [5:0] PRE_LEN = 6'h20;
	localparam logic [5:0] ADDR_LAST = 6'h09;
	localparam logic [5:0] DATA_LAST = 6'h0f;
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [4:0] STAT_REG_IDX = 5'h11;
	localparam logic [15:0] REG_RST = 16'h0000;

	typedef enum logic [2:0] {
		M_PRE, M_IDLE, M_START, M_OP, M_ADDR, M_TA, M_DATA
	} pms_mdio_e;

	// start threshold in dibit entries: 1->4b, 2->8b, 3->12b, 0->16b
	function automatic logic [4:0] pms_thr(input logic [1:0] thr);
		pms_thr = (thr == 2'h0) ? 5'h08 : {2'h0, thr, 1'b0};
	endfunction : pms_thr

endpackage : pms_pkg

// ### verilog/pms_top.sv
// mii/rmii data path, collision/carrier logic and management slave
//
// Operation
// - rmii chosen only by strap, mii by register
// - mii clocks run 2.5 or 25 mhz
// - half duplex collision when rx and tx
// - 10m transmit collision waits seven bits
// - receive collision reported at once
// - heartbeat pulses collision after 10m packet
// - 10m carrier sense on squelch valid data
// - 100m carrier sense on link and zeros
// - duplex selects carrier sense, ends with packet
// - rmii moves two bits per clock
// - rmii gives separate receive data valid
// - rmii 10m transfers every tenth clock
// - buffer overrun/underrun corrupts frame, sets status
// - start threshold field sets buffer fill
// - thirty-two 16-bit management registers
// - ignore frames until preamble, also after errors
// - frames start with pattern 01
// - read turnaround: release, then drive zero
// - frame is start, op, addresses, ta, data
// - one idle bit between frames suffices
// - answer only strapped management address
`timescale 1ns/1ps
module pms_top import pms_pkg::*; #(
	parameter int EB_DEPTH = 16
) (
	// clocks and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_ref_clk,
	// straps and configuration, i_mclk domain
	input wire logic i_strap_rmii,
	input wire logic [4:0] i_strap_mgmt_address,
	input wire logic i_force_mii,
	input wire logic i_speed100,
	input wire logic i_full_duplex,
	input wire logic i_hb_en,
	input wire logic [1:0] i_eb_thresh,
	input wire logic i_eb_clr,
	// status, i_mclk domain
	output logic o_eb_overrun,
	output logic o_eb_underrun,
	output logic o_rmii_mode,
	output logic o_mgmt_synced,
	// management pins
	input wire logic i_mdc,
	input wire logic i_mdio_i,
	output logic o_mdio_o,
	output logic o_mdio_oe,
	// mac transmit, i_ref_clk domain
	input wire logic i_tx_en,
	input wire logic [3:0] i_txd,
	output logic o_tx_clk,
	// mac receive, i_ref_clk domain
	output logic o_rx_clk,
	output logic [3:0] o_rxd,
	output logic o_rx_dv,
	output logic o_rx_er,
	output logic o_crs,
	output logic o_col,
	output logic o_crs_dv,
	// line side, i_ref_clk domain
	input wire logic i_ln_rx_act,
	input wire logic i_ln_rx_vld,
	input wire logic [1:0] i_ln_rx_dibit,
	input wire logic i_ln_squelch_ok,
	input wire logic i_ln_sd,
	input wire logic i_ln_zeros2,
	output logic o_ln_tx_en,
	output logic [3:0] o_ln_txd
);

	localparam int AW = $clog2(EB_DEPTH);
	localparam int CW = AW + 1;

	// ------------------------------------------------------------
	// link domain state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [5:0] cfg1;
		logic [5:0] cfg2;
		logic [4:0] div;
		logic clk_o;
		logic [3:0] txd;
		logic tx_en;
		logic tx_ph;
		logic [1:0] tx_lo;
		logic [EB_DEPTH-1:0][1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
		logic rx_dv;
		logic bad;
		logic [3:0] rxd;
		logic ov_tgl;
		logic un_tgl;
		logic crs_rx;
		logic rx_first;
		logic [3:0] bitdiv;
		logic [2:0] colcnt;
		logic col;
		logic crs;
		logic crs_dv;
		logic tx_prev;
		logic [1:0] hb_ph;
		logic [6:0] hb_cnt;
	} pms_lnk_s;

	pms_lnk_s l_r, l_nxt;
	logic tick;
	logic [4:0] div_max;
	logic [CW-1:0] need;
	logic push, pop, colliding;

	wire logic c_rmii = l_r.cfg2[0];
	wire logic c_spd = l_r.cfg2[1];
	wire logic c_fdx = l_r.cfg2[2];
	wire logic c_hb = l_r.cfg2[3];
	wire logic [1:0] c_thr = l_r.cfg2[5:4];

	// link domain next state
	always_comb begin
		l_nxt = l_r;
		l_nxt.cfg1 = {i_eb_thresh, i_hb_en, i_full_duplex, i_speed100,
			o_rmii_mode};
		l_nxt.cfg2 = l_r.cfg1;
		if (c_rmii)
			div_max = (c_spd ? RMII100_DIV : RMII10_DIV) - 5'h01;
		else
			div_max = (c_spd ? MII100_DIV : MII10_DIV) - 5'h01;
		tick = (l_r.div == 5'h00);
		l_nxt.div = tick ? div_max : l_r.div - 5'h01;
		l_nxt.clk_o = l_nxt.div > {1'b0, div_max[4:1]};
		// transmit: two dibits build one nibble in rmii
		if (tick) begin
			if (!c_rmii) begin
				l_nxt.txd = i_txd;
				l_nxt.tx_en = i_tx_en;
			end else if (!i_tx_en) begin
				l_nxt.tx_ph = 1'b0;
				l_nxt.tx_en = 1'b0;
			end else if (!l_r.tx_ph) begin
				l_nxt.tx_lo = i_txd[1:0];
				l_nxt.tx_ph = 1'b1;
			end else begin
				l_nxt.txd = {i_txd[1:0], l_r.tx_lo};
				l_nxt.tx_en = 1'b1;
				l_nxt.tx_ph = 1'b0;
			end
		end
		// elasticity buffer write side, overrun flags frame
		need = c_rmii ? CW'(1) : CW'(2);
		push = i_ln_rx_vld && i_ln_rx_act;
		pop = 1'b0;
		if (push) begin
			if (l_r.cnt == CW'(EB_DEPTH)) begin
				push = 1'b0;
				l_nxt.bad = 1'b1;
				l_nxt.ov_tgl = ~l_r.ov_tgl;
			end else begin
				l_nxt.mem[l_r.wp] = i_ln_rx_dibit;
				l_nxt.wp = l_r.wp + AW'(1);
			end
		end
		// read side starts at threshold fill
		if (tick) begin
			if (!l_r.rx_dv) begin
				if (i_ln_rx_act && l_r.cnt >= CW'(pms_thr(c_thr))) begin
					l_nxt.rx_dv = 1'b1;
					// an overrun in this same cycle still wins
					l_nxt.bad = l_nxt.ov_tgl != l_r.ov_tgl;
					pop = 1'b1;
				end
			end else if (l_r.cnt >= need) begin
				pop = 1'b1;
			end else if (i_ln_rx_act) begin
				l_nxt.bad = 1'b1;
				l_nxt.un_tgl = ~l_r.un_tgl;
			end else begin
				l_nxt.rx_dv = 1'b0;
			end
		end
		if (pop) begin
			// corrupted data forces a bad frame check
			if (c_rmii)
				l_nxt.rxd = {2'h0, l_r.mem[l_r.rp] ^ {2{l_nxt.bad}}};
			else
				l_nxt.rxd = {l_r.mem[l_r.rp + AW'(1)], l_r.mem[l_r.rp]}
					^ {4{l_nxt.bad}};
			l_nxt.rp = l_r.rp + need[AW-1:0];
		end
		l_nxt.cnt = l_r.cnt + CW'(push) - (pop ? need : CW'(0));
		if (!l_nxt.rx_dv && !i_ln_rx_act && tick) begin
			// frame over: drop leftovers
			l_nxt.wp = l_nxt.rp;
			l_nxt.cnt = '0;
		end
		// carrier detect, held to end of packet
		if (!i_ln_rx_act)
			l_nxt.crs_rx = 1'b0;
		else if (c_spd ? (i_ln_sd && i_ln_zeros2) : i_ln_squelch_ok)
			l_nxt.crs_rx = 1'b1;
		l_nxt.crs = l_nxt.crs_rx || (!c_fdx && i_tx_en);
		// crs_dv plus separate rx_dv in rmii
		l_nxt.crs_dv = c_rmii && (l_nxt.crs_rx || l_nxt.rx_dv);
		if (!i_ln_rx_act)
			l_nxt.rx_first = 1'b0;
		else if (!i_tx_en)
			l_nxt.rx_first = 1'b1;
		colliding = !c_fdx && i_tx_en && i_ln_rx_act;
		l_nxt.bitdiv = (l_r.bitdiv == 4'(BIT10_CYC - 1)) ? 4'h0
			: l_r.bitdiv + 4'h1;
		if (!colliding)
			l_nxt.colcnt = 3'h0;
		else if (l_r.bitdiv == 4'h0 && l_r.colcnt != COL_HOLD_BITS)
			l_nxt.colcnt = l_r.colcnt + 3'h1;
		// heartbeat: delay then sqe pulse after 10m packet
		l_nxt.tx_prev = i_tx_en;
		case (l_r.hb_ph)
			2'h0: begin
				if (l_r.tx_prev && !i_tx_en && c_hb && !c_spd) begin
					l_nxt.hb_ph = 2'h1;
					l_nxt.hb_cnt = 7'(HB_DLY_CYC - 1);
				end
			end
			2'h1: begin
				l_nxt.hb_cnt = l_r.hb_cnt - 7'h01;
				if (l_r.hb_cnt == 7'h00) begin
					l_nxt.hb_ph = 2'h2;
					l_nxt.hb_cnt = 7'(SQE_CYC - 1);
				end
			end
			2'h2: begin
				l_nxt.hb_cnt = l_r.hb_cnt - 7'h01;
				if (l_r.hb_cnt == 7'h00)
					l_nxt.hb_ph = 2'h0;
			end
			default: l_nxt.hb_ph = 2'h0;
		endcase
		// 10m transmit waits seven bits, else at once
		l_nxt.col = (colliding && (c_spd || l_r.rx_first
			|| l_nxt.colcnt == COL_HOLD_BITS)) || l_nxt.hb_ph == 2'h2;
	end

	// link domain registers
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			l_r <= '0;
		else
			l_r <= l_nxt;
	end

	assign o_tx_clk = l_r.clk_o;
	assign o_rx_clk = l_r.clk_o;
	assign o_ln_txd = l_r.txd;
	assign o_ln_tx_en = l_r.tx_en;
	assign o_rxd = l_r.rxd;
	assign o_rx_dv = l_r.rx_dv;
	assign o_rx_er = l_r.rx_dv && l_r.bad;
	assign o_crs = l_r.crs;
	assign o_col = l_r.col;
	assign o_crs_dv = l_r.crs_dv;

	// ------------------------------------------------------------
	// management domain state
	// ------------------------------------------------------------
	typedef struct packed {
		logic latched;
		logic rmii;
		logic [4:0] addr;
		logic [2:0] mdc_s;
		logic [1:0] dio_s;
		logic [2:0] ov_s;
		logic [2:0] un_s;
		logic ov_st;
		logic un_st;
		pms_mdio_e st;
		logic [5:0] cnt;
		logic [15:0] sh;
		logic rd;
		logic hit;
		logic [4:0] ra;
		logic [15:0] rdsh;
		logic oe;
		logic dout;
		logic synced;
		logic [31:0][15:0] regs;
	} pms_mgt_s;

	pms_mgt_s m_r, m_nxt;
	logic rise, b;
	logic [9:0] abits;

	// management next state
	always_comb begin
		m_nxt = m_r;
		// straps caught once after reset release
		if (!m_r.latched) begin
			m_nxt.latched = 1'b1;
			m_nxt.rmii = i_strap_rmii;
			m_nxt.addr = i_strap_mgmt_address;
		end
		m_nxt.mdc_s = {m_r.mdc_s[1:0], i_mdc};
		m_nxt.dio_s = {m_r.dio_s[0], i_mdio_i};
		// overrun/underrun events, set wins over clear
		m_nxt.ov_s = {m_r.ov_s[1:0], l_r.ov_tgl};
		m_nxt.un_s = {m_r.un_s[1:0], l_r.un_tgl};
		m_nxt.ov_st = (m_r.ov_s[2] ^ m_r.ov_s[1]) || (m_r.ov_st && !i_eb_clr);
		m_nxt.un_st = (m_r.un_s[2] ^ m_r.un_s[1]) || (m_r.un_st && !i_eb_clr);
		rise = m_r.mdc_s[1] && !m_r.mdc_s[2];
		b = m_r.dio_s[1];
		abits = {m_r.sh[8:0], b};
		if (rise) begin
			m_nxt.cnt = m_r.cnt + 6'h01;
			m_nxt.sh = {m_r.sh[14:0], b};
			case (m_r.st)
				M_PRE: begin
					m_nxt.synced = 1'b0;
					if (!b)
						m_nxt.cnt = 6'h00;
					else if (m_r.cnt == PRE_LEN - 6'h01) begin
						m_nxt.st = M_IDLE;
						m_nxt.synced = 1'b1;
					end
				end
				// any number of idle ones between frames
				M_IDLE: begin
					if (!b)
						m_nxt.st = M_START;
				end
				M_START: begin
					m_nxt.cnt = 6'h00;
					m_nxt.st = b ? M_OP : M_PRE;
				end
				// opcode must be read or write
				M_OP: begin
					if (m_r.cnt[0]) begin
						m_nxt.cnt = 6'h00;
						m_nxt.rd = ({m_r.sh[0], b} == OP_RD);
						if ({m_r.sh[0], b} == OP_RD || {m_r.sh[0], b} == OP_WR)
							m_nxt.st = M_ADDR;
						else
							m_nxt.st = M_PRE;
					end
				end
				M_ADDR: begin
					if (m_r.cnt == ADDR_LAST) begin
						m_nxt.cnt = 6'h00;
						m_nxt.st = M_TA;
						m_nxt.hit = (abits[9:5] == m_r.addr);
						m_nxt.ra = abits[4:0];
						m_nxt.rdsh = (abits[4:0] == STAT_REG_IDX)
							? {8'h00, m_r.ov_st, m_r.un_st, m_r.rmii && !i_force_mii,
							m_r.addr} : m_r.regs[abits[4:0]];
					end
				end
				M_TA: begin
					if (m_r.cnt == 6'h00) begin
						if (!m_r.rd && !b)
							m_nxt.st = M_PRE;
						else if (m_r.rd && m_r.hit) begin
							m_nxt.oe = 1'b1;
							m_nxt.dout = 1'b0;
						end
					end else begin
						m_nxt.cnt = 6'h00;
						if (!m_r.rd && b)
							m_nxt.st = M_PRE;
						else begin
							m_nxt.st = M_DATA;
							m_nxt.dout = m_r.rdsh[15];
							m_nxt.rdsh = {m_r.rdsh[14:0], 1'b0};
						end
					end
				end
				M_DATA: begin
					m_nxt.dout = m_r.rdsh[15];
					m_nxt.rdsh = {m_r.rdsh[14:0], 1'b0};
					if (m_r.cnt == DATA_LAST) begin
						m_nxt.st = M_IDLE;
						m_nxt.oe = 1'b0;
						if (!m_r.rd && m_r.hit)
							m_nxt.regs[m_r.ra] = {m_r.sh[14:0], b};
					end
				end
				default: m_nxt.st = M_PRE;
			endcase
		end
	end

	// management registers
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			m_r <= '0;
			m_r.regs <= {32{REG_RST}};
		end else
			m_r <= m_nxt;
	end

	assign o_mdio_o = m_r.dout;
	assign o_mdio_oe = m_r.oe;
	// rmii only by strap; register may force mii
	assign o_rmii_mode = m_r.rmii && !i_force_mii;
	assign o_eb_overrun = m_r.ov_st;
	assign o_eb_underrun = m_r.un_st;
	assign o_mgmt_synced = m_r.synced;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence ta_release_s;
		m_r.st == M_TA && !m_r.oe;
	endsequence
	sequence ta_drive_s;
		m_r.oe && !m_r.dout;
	endsequence

	rx_coll_now_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(colliding && l_r.rx_first) |=> l_r.col)
		else $error("receive collision not reported at once");
	tx_coll_wait_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(!c_spd && !l_r.rx_first && l_r.colcnt < 3'h6 && l_r.hb_ph == 2'h0)
		|=> !l_r.col)
		else $error("10m transmit collision reported early");
	fdx_no_col_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(c_fdx && $stable(c_fdx) && l_r.hb_ph == 2'h0) |=> !l_r.col)
		else $error("collision in full duplex");
	fdx_crs_rx_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		c_fdx |=> (l_r.crs == l_r.crs_rx))
		else $error("full duplex carrier not receive only");
	rmii_cadence_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(tick && c_rmii && !c_spd && $stable(l_r.cfg2)) |=> !tick [*8])
		else $error("rmii 10m cadence wrong");
	eb_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		$rose(l_r.rx_dv) |-> $past(l_r.cnt) >= CW'(pms_thr($past(c_thr))))
		else $error("buffer output before threshold");
	eb_over_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_ln_rx_vld && i_ln_rx_act && l_r.cnt == CW'(EB_DEPTH))
		|=> (l_r.ov_tgl != $past(l_r.ov_tgl)) && l_r.bad)
		else $error("overrun not flagged");
	ta_order_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(rise && m_r.st == M_TA && m_r.cnt == 6'h00 && m_r.rd && m_r.hit)
		|-> ta_release_s ##1 ta_drive_s)
		else $error("read turnaround order wrong");
	pre_gate_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		m_r.oe |-> m_r.synced && m_r.hit && m_r.rd)
		else $error("mdio driven without preamble or match");
	hb_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(l_r.hb_ph == 2'h1 && l_r.hb_cnt == 7'h00) |=> l_r.col [*8])
		else $error("heartbeat pulse missing");

endmodule : pms_top

// ### dv/pms_sta_model.sv
// station management model: drives mdc and mdio, resolves the shared line
`timescale 1ns/1ps
module pms_sta_model import pms_pkg::*; (
	// timing clock
	input wire logic i_mclk,
	// device side of the shared line
	input wire logic i_mdio_o,
	input wire logic i_mdio_oe,
	// resolved pins
	output logic o_mdc,
	output logic o_mdio
);
	logic sta_oe;
	logic sta_o;

	// pull-up takes the line high when nobody drives it
	assign o_mdio = i_mdio_oe ? i_mdio_o : (sta_oe ? sta_o : 1'b1);

	// mdc stands low between frames
	initial begin
		o_mdc = 1'b0;
		sta_oe = 1'b0;
		sta_o = 1'b0;
	end

	// mdc of nine mclk, sample on rise
	task automatic bit_cyc(input logic oe, input logic v, output logic s);
		@(posedge i_mclk);
		sta_oe <= oe;
		sta_o <= v;
		repeat (4) @(posedge i_mclk);
		s = o_mdio;
		o_mdc <= 1'b1;
		repeat (4) @(posedge i_mclk);
		o_mdc <= 1'b0;
	endtask : bit_cyc

	task automatic frame(input logic pre, input logic [1:0] op,
		input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd,
		output logic [15:0] rd, output logic ta);
		logic [31:0] f;
		logic s;
		f = {2'b01, op, phy, rg, 2'b10, wd};
		rd = 16'h0000;
		ta = 1'b1;
		if (pre) begin
			repeat (32) bit_cyc(1'b1, 1'b1, s);
		end
		// read: line released from the first turnaround bit on
		for (int i = 31; i >= 0; i--) begin
			bit_cyc(op != OP_RD || i > 17, f[i], s);
			rd = {rd[14:0], s};
			if (i == 16) begin
				ta = s;
			end
		end
		bit_cyc(1'b0, 1'b1, s);
	endtask : frame
endmodule : pms_sta_model

// ### dv/test_pms_top.sv
// self-checking bench for the mii/rmii and management block
`timescale 1ns/1ps
module test_pms_top import pms_pkg::*; ;
	logic mclk = 1'b0;
	logic rclk = 1'b0;
	logic rst_n = 1'b0;
	logic fmii = 1'b0;
	logic s100 = 1'b1;
	logic fdx = 1'b0;
	logic hb = 1'b0;
	logic clr = 1'b0;
	logic [1:0] thr = 2'h0;
	logic tx_en = 1'b0;
	logic act = 1'b0;
	logic vld = 1'b0;
	logic sq = 1'b0;
	logic sd = 1'b0;
	logic z2 = 1'b0;
	logic mdc, mdio, mo, moe, ov, un, rmii, sync, txc, rdv, crs, col, cdv;
	logic rxc, rer, ltxe;
	logic [3:0] txd = 4'h0;
	logic [3:0] ltxd;
	logic ta;
	logic [15:0] rd;
	logic [3:0] rxd;
	int num_errors = 0;
	int checked = 0;
	localparam logic [4:0] ADR = 5'h03;

	// clocks: 40 ns main, 30 ns link
	initial forever #20 mclk = ~mclk;
	initial forever #15 rclk = ~rclk;

	pms_top dut_u (.i_mclk(mclk), .i_arst_n(rst_n), .i_ref_clk(rclk),
		.i_strap_rmii(1'b1), .i_strap_mgmt_address(ADR), .i_force_mii(fmii),
		.i_speed100(s100), .i_full_duplex(fdx), .i_hb_en(hb),
		.i_eb_thresh(thr), .i_eb_clr(clr), .o_eb_overrun(ov),
		.o_eb_underrun(un), .o_rmii_mode(rmii), .o_mgmt_synced(sync),
		.i_mdc(mdc), .i_mdio_i(mdio), .o_mdio_o(mo), .o_mdio_oe(moe),
		.i_tx_en(tx_en), .i_txd(txd), .o_tx_clk(txc), .o_rx_clk(rxc),
		.o_rxd(rxd), .o_rx_dv(rdv), .o_rx_er(rer), .o_crs(crs), .o_col(col),
		.o_crs_dv(cdv), .i_ln_rx_act(act), .i_ln_rx_vld(vld),
		.i_ln_rx_dibit(2'h2), .i_ln_squelch_ok(sq), .i_ln_sd(sd),
		.i_ln_zeros2(z2), .o_ln_tx_en(ltxe), .o_ln_txd(ltxd));

	pms_sta_model sta_u (.i_mclk(mclk), .i_mdio_o(mo), .i_mdio_oe(moe),
		.o_mdc(mdc), .o_mdio(mdio));

	// compare and count
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic rw(input int n);
		repeat (n) @(posedge rclk);
	endtask : rw

	// link clocks between two tx clock rises
	task automatic per(input logic [4:0] exp);
		realtime t0;
		@(posedge txc);
		t0 = $realtime;
		@(posedge txc);
		chk("tx_clk", 16'(int'(($realtime - t0) / 30.0)), 16'(exp));
		rw(1);
		chk("rx_clk", 16'(rxc), 16'h0001);
	endtask : per

	task automatic finish_test();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// watchdog
	initial begin
		#2000000;
		num_errors++;
		finish_test();
	end

	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("rmii", 16'(rmii), 16'h0001);
		fmii <= 1'b1;
		rw(3);
		chk("rmii", 16'(rmii), 16'h0000);
		// ------------------------------------------------------------
		// management frames
		// ------------------------------------------------------------
		sta_u.frame(1'b0, OP_RD, ADR, 5'h05, 16'h0000, rd, ta);
		chk("nopre", rd, 16'hffff);
		sta_u.frame(1'b1, OP_WR, ADR, 5'h05, 16'ha5c3, rd, ta);
		chk("synced", 16'(sync), 16'h0001);
		sta_u.frame(1'b0, OP_WR, 5'h04, 5'h05, 16'h1234, rd, ta);
		sta_u.frame(1'b0, OP_RD, ADR, 5'h05, 16'h0000, rd, ta);
		chk("rdata", rd, 16'ha5c3);
		chk("ta2", 16'(ta), 16'h0000);
		sta_u.frame(1'b0, OP_RD, 5'h04, 5'h05, 16'h0000, rd, ta);
		chk("other", rd, 16'hffff);
		sta_u.frame(1'b0, 2'h3, ADR, 5'h05, 16'h0000, rd, ta);
		chk("badop", 16'(sync), 16'h0000);
		$display("test mgmt done");
		// ------------------------------------------------------------
		// mii clocks, carrier and collision
		// ------------------------------------------------------------
		per(MII100_DIV);
		s100 <= 1'b0;
		rw(5);
		per(MII10_DIV);
		s100 <= 1'b1;
		rw(5);
		tx_en <= 1'b1;
		rw(4);
		chk("crs_tx", 16'(crs), 16'h0001);
		act <= 1'b1;
		sd <= 1'b1;
		z2 <= 1'b1;
		rw(4);
		chk("col100", 16'(col), 16'h0001);
		tx_en <= 1'b0;
		rw(4);
		chk("crs100", 16'(crs), 16'h0001);
		act <= 1'b0;
		fdx <= 1'b1;
		rw(5);
		chk("crs_end", 16'(crs), 16'h0000);
		tx_en <= 1'b1;
		act <= 1'b1;
		rw(5);
		chk("col_fdx", 16'(col), 16'h0000);
		tx_en <= 1'b0;
		act <= 1'b0;
		fdx <= 1'b0;
		s100 <= 1'b0;
		rw(5);
		// ten meg transmit-first waits seven bits
		tx_en <= 1'b1;
		rw(3);
		act <= 1'b1;
		rw(25);
		chk("col_early", 16'(col), 16'h0000);
		rw(20);
		chk("col_late", 16'(col), 16'h0001);
		tx_en <= 1'b0;
		act <= 1'b0;
		rw(150);
		act <= 1'b1;
		sq <= 1'b1;
		rw(4);
		chk("crs10", 16'(crs), 16'h0001);
		tx_en <= 1'b1;
		rw(4);
		chk("col_rx", 16'(col), 16'h0001);
		act <= 1'b0;
		sq <= 1'b0;
		hb <= 1'b1;
		rw(20);
		tx_en <= 1'b0;
		rw(30);
		chk("hb_wait", 16'(col), 16'h0000);
		rw(45);
		chk("hb_on", 16'(col), 16'h0001);
		rw(60);
		chk("hb_off", 16'(col), 16'h0000);
		$display("test mii done");
		// ------------------------------------------------------------
		// rmii cadence and receive buffer
		// ------------------------------------------------------------
		fmii <= 1'b0;
		hb <= 1'b0;
		fdx <= 1'b1;
		rw(25);
		per(RMII10_DIV);
		s100 <= 1'b1;
		rw(15);
		// two dibits pair into one nibble
		txd <= 4'h1;
		tx_en <= 1'b1;
		rw(1);
		txd <= 4'h2;
		rw(2);
		chk("ln_txd", 16'(ltxd), 16'h0009);
		chk("ln_tx_en", 16'(ltxe), 16'h0001);
		tx_en <= 1'b0;
		rw(2);
		act <= 1'b1;
		vld <= 1'b1;
		rw(7);
		vld <= 1'b0;
		rw(3);
		chk("dv_below", 16'(rdv), 16'h0000);
		vld <= 1'b1;
		rw(1);
		vld <= 1'b0;
		rw(3);
		chk("dv_thr", 16'(rdv), 16'h0001);
		chk("crs_dv", 16'(cdv), 16'h0001);
		chk("rxd", 16'(rxd[1:0]), 16'h0002);
		rw(20);
		chk("under", 16'(un), 16'h0001);
		chk("rx_er", 16'(rer), 16'h0001);
		act <= 1'b0;
		rw(20);
		chk("dv_end", 16'(rdv), 16'h0000);
		sta_u.frame(1'b1, OP_RD, ADR, STAT_REG_IDX, 16'h0000, rd, ta);
		chk("status", rd, {8'h00, 1'b0, 1'b1, 1'b1, ADR});
		@(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("clr", 16'({ov, un}), 16'h0000);
		rw(1);
		thr <= 2'h1;
		rw(3);
		act <= 1'b1;
		vld <= 1'b1;
		rw(1);
		vld <= 1'b0;
		rw(4);
		chk("dv_thr1_lo", 16'(rdv), 16'h0000);
		vld <= 1'b1;
		rw(1);
		vld <= 1'b0;
		rw(3);
		chk("dv_thr1", 16'(rdv), 16'h0001);
		act <= 1'b0;
		$display("test rmii done");
		finish_test();
	end
endmodule : test_pms_top
